// ==== wsa_edge_det.sv ====
/*
 Per-bit edge detector with polarity and either-edge selection.
 Assumes inputs synchronous to clk_in.
*/
`timescale 1ns/1ps
module wsa_edge_det #(
	parameter int W = 1
) (
	input wire logic clk_in, // Device clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic [W-1:0] sig_in, // Sampled lines
	input wire logic [W-1:0] pol_in, // 0 rising, 1 falling
	input wire logic [W-1:0] both_in, // Either-edge select
	output logic [W-1:0] evt_out // Edge seen this cycle
);
	logic [W-1:0] prev_q;
	logic armed_q;

	// Previous sample and arming
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_q <= '0;
			armed_q <= 1'b0;
		end else if (ce_in) begin
			prev_q <= sig_in;
			armed_q <= 1'b1;
		end
	end

	// Edge selection per bit
	always_comb begin
		evt_out = {W{armed_q}} & ((both_in & (sig_in ^ prev_q)) |
			(~both_in & pol_in & prev_q & ~sig_in) |
			(~both_in & ~pol_in & ~prev_q & sig_in));
	end
endmodule

// ==== wsa_host_model.sv ====
/*
 Host chipset model: register cycles out, SMI pin in.
 Assumes strobes sampled on rising clk_in.
*/
`timescale 1ns/1ps
module wsa_host_model (
	input wire logic clk_in, // Device clock
	input wire logic [7:0] rdata_in, // Read data
	input wire logic pin_in, // SMI pin level
	input wire logic oe_in, // SMI pin enable
	output logic [7:0] addr_out, // Offset
	output logic wr_out, // Write strobe
	output logic rd_out, // Read strobe
	output logic [7:0] wdata_out, // Write data
	output logic smi_wire_out // Resolved pin
);
	// Pull-up when undriven
	assign smi_wire_out = oe_in ? pin_in : 1'b1;
	// Idle bus
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// Read, data after strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(negedge clk_in);
		d = rdata_in;
	endtask
endmodule

// ==== wsa_pkg.sv ====
/*
 Watchdog and SMI aggregator constants: offsets, fields, resets, timing.
 Assumes a 40 MHz device clock and 8-bit register accesses.
*/
package wsa_pkg;
	// Clock and timing
	localparam int CLK_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WDT_SECOND_CYCLES = CLK_HZ;
	localparam int WDT_MINUTE_SECONDS = 60;
	localparam int P12_PULSE_NS = 20;
	localparam int P12_PULSE_CYCLES = (P12_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(P12_PULSE_NS / CLK_PERIOD_NS);

	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int GPIO_W = 28;
	localparam int DEV1_W = 7;
	localparam int DEV2_W = 3;
	localparam int CHAN_W = 4;
	localparam int PULSE_W = 4;

	// Runtime register offsets
	localparam logic [7:0] OFF_SMI_STS1 = 8'h40;
	localparam logic [7:0] OFF_SMI_STATUS_TWO = 8'h41;
	localparam logic [7:0] OFF_SMI_STS3 = 8'h42;
	localparam logic [7:0] OFF_SMI_STS4 = 8'h43;
	localparam logic [7:0] OFF_SMI_STS5 = 8'h44;
	localparam logic [7:0] OFF_SMI_EN1 = 8'h48;
	localparam logic [7:0] OFF_SMI_EN2 = 8'h49;
	localparam logic [7:0] OFF_SMI_EN3 = 8'h4a;
	localparam logic [7:0] OFF_SMI_EN4 = 8'h4b;
	localparam logic [7:0] OFF_SMI_EN5 = 8'h4c;
	localparam logic [7:0] OFF_PIN_CTRL = 8'h4f;
	localparam logic [7:0] OFF_EDGE_SELECT = 8'h21;
	localparam logic [7:0] OFF_WDT_CONFIG = 8'h54;
	localparam logic [7:0] OFF_WDT_UNITS = 8'h55;
	localparam logic [7:0] OFF_WDT_RELOAD = 8'h56;
	localparam logic [7:0] OFF_WDT_CONTROL = 8'h57;
	localparam logic [7:0] OFF_SLEEP_LOW = 8'h60;
	localparam logic [7:0] OFF_SLEEP_HIGH = 8'h61;
	localparam logic [7:0] OFF_SMI_STATUS_SEVEN = 8'h64;
	localparam logic [7:0] OFF_SMI_ENABLE_SEVEN = 8'h66;

	// Field positions
	localparam int BIT_UNITS_MIN = 7;
	localparam int BIT_WDT_STATUS = 0;
	localparam int BIT_WDT_FORCE = 2;
	localparam int BIT_CFG_KBD = 0;
	localparam int BIT_CFG_MOUSE = 1;
	localparam int BIT_CFG_JOY = 2;
	localparam int LSB_CFG_CHAN = 4;
	localparam int BIT_EN2_PIN = 7;
	localparam int BIT_EN2_SERIRQ = 6;
	localparam int BIT_ES_P12_BOTH = 0;
	localparam int BIT_ES_P16_BOTH = 1;
	localparam int BIT_ES_P12_POL = 2;
	localparam int BIT_PIN_PUSHPULL = 7;
	localparam int BIT_PIN_POL = 0;
	localparam int BIT_SLEEP_EN = 5;
	localparam int BIT_STS7_SLEEP = 5;
	localparam logic [7:0] SLEEP_HIGH_MASK = 8'hdf;
	localparam logic [7:0] STS7_MASK = 8'h2f;

	// Reset values
	localparam logic [7:0] RST_WDT_RELOAD = 8'h00;
	localparam logic [7:0] RST_REG = 8'h00;
endpackage

// ==== wsa_prescaler.sv ====
/*
 Second and minute tick generator for the watchdog countdown.
 Assumes restart_in pulses on every reload.
*/
`timescale 1ns/1ps
module wsa_prescaler #(
	parameter int SEC_CYCLES = 40000000,
	parameter int MIN_SECONDS = 60
) (
	input wire logic clk_in, // Device clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic run_in, // Countdown active
	input wire logic restart_in, // Restart prescaler
	input wire logic minutes_in, // Minute units select
	output logic tick_out // One-cycle unit tick
);
	localparam int CW = $clog2(SEC_CYCLES + 1);
	localparam logic [CW-1:0] CYC_LAST = CW'(SEC_CYCLES - 1);
	localparam logic [5:0] SEC_LAST = 6'(MIN_SECONDS - 1);
	logic [CW-1:0] cyc_q;
	logic [5:0] sec_q;
	logic sec_tick;

	assign sec_tick = run_in && (cyc_q == CYC_LAST);

	// Cycles per second
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cyc_q <= '0;
		end else if (ce_in) begin
			if (restart_in || !run_in || sec_tick) begin
				cyc_q <= '0;
			end else begin
				cyc_q <= cyc_q + 1'b1;
			end
		end
	end

	// Seconds counter and unit tick
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sec_q <= '0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			tick_out <= 1'b0;
			if (restart_in || !run_in) begin
				sec_q <= '0;
			end else if (sec_tick) begin
				if (!minutes_in) begin
					tick_out <= 1'b1;
					sec_q <= '0;
				end else if (sec_q == SEC_LAST) begin
					tick_out <= 1'b1;
					sec_q <= '0;
				end else begin
					sec_q <= sec_q + 1'b1;
				end
			end
		end
	end
endmodule

// ==== wsa_props.sv ====
/*
 Checker for the watchdog and SMI aggregator top-level ports.
 Assumes binding into every wsa_top instance.
*/
`timescale 1ns/1ps
module wsa_props
	import wsa_pkg::*;
#(
	parameter int SECOND_CYCLES = 8
) (
	input wire logic clk_in, // Device clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic [ADDR_W-1:0] reg_addr_in, // Offset
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	input wire logic [DATA_W-1:0] reg_wdata_in, // Write data
	input wire logic [DATA_W-1:0] reg_rdata_out, // Read data
	input wire logic wdt_irq_out, // Watchdog irq
	input wire logic [CHAN_W-1:0] wdt_irq_chan_out, // Channel
	input wire logic group_smi_signal_out, // Group SMI
	input wire logic smi_output_pin_out, // Pin level
	input wire logic smi_output_pin_oe_out, // Pin enable
	input wire logic serirq_smi_out // IRQ2 slot
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [7:0] en2_q;
	logic [7:0] pctl_q;
	////////////////////////////////////////////////////////////////////////////
	// Routing and pin control mirror
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en2_q <= 8'h00;
			pctl_q <= 8'h00;
		end else if (ce_in && reg_wr_in) begin
			if (reg_addr_in == OFF_SMI_EN2) en2_q <= reg_wdata_in;
			if (reg_addr_in == OFF_PIN_CTRL) pctl_q <= reg_wdata_in;
		end
	end
	sequence s_wr(logic [7:0] a);
		ce_in && reg_wr_in && reg_addr_in == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		ce_in && reg_rd_in && reg_addr_in == a;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	a_chan_copy: assert property (s_wr(OFF_WDT_CONFIG) |-> ##2
		wdt_irq_chan_out == $past(reg_wdata_in[7:4], 2)) else $error("channel not copied");
	a_irq_mapped: assert property (wdt_irq_out |-> wdt_irq_chan_out != 4'h0)
		else $error("irq without channel");
	a_force_irq: assert property (s_wr(OFF_WDT_CONTROL) ##0 reg_wdata_in[BIT_WDT_FORCE]
		##0 wdt_irq_chan_out != 4'h0 |-> ##[1:3] wdt_irq_out) else $error("force no irq");
	a_force_reads0: assert property (s_rd(OFF_WDT_CONTROL) |=>
		!reg_rdata_out[BIT_WDT_FORCE]) else $error("force bit stuck");
	a_sleep_reads0: assert property (s_rd(OFF_SLEEP_HIGH) |=>
		!reg_rdata_out[BIT_SLEEP_EN]) else $error("sleep bit stuck");
	a_serirq_gate: assert property (serirq_smi_out ==
		(group_smi_signal_out && $past(en2_q[BIT_EN2_SERIRQ]))) else $error("serirq gate");
	a_pin_od: assert property (!$past(pctl_q[7]) && !$past(pctl_q[0]) |->
		smi_output_pin_oe_out == (group_smi_signal_out && $past(en2_q[BIT_EN2_PIN])) &&
		!smi_output_pin_out) else $error("open drain pin");
	a_pin_pp: assert property ($past(pctl_q[7]) |-> smi_output_pin_oe_out &&
		smi_output_pin_out == ((group_smi_signal_out && $past(en2_q[BIT_EN2_PIN])) ~^
		$past(pctl_q[0]))) else $error("push pull pin");
endmodule
bind wsa_top wsa_props #(.SECOND_CYCLES(SECOND_CYCLES)) props_u (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.wdt_irq_out(wdt_irq_out), .wdt_irq_chan_out(wdt_irq_chan_out),
	.group_smi_signal_out(group_smi_signal_out), .smi_output_pin_out(smi_output_pin_out),
	.smi_output_pin_oe_out(smi_output_pin_oe_out), .serirq_smi_out(serirq_smi_out));

// ==== wsa_top.sv ====
/*
 Watchdog timer and SMI group aggregator with its runtime registers.
 Assumes one-cycle host read/write strobes and inputs synchronous to clk_in.
*/
//
// Overview of operation
// R01: Timeout 1 to 255 units; units bit 7 picks minutes.
// R02: Reload zero disables; zero after reset.
// R03: Nonzero reload write loads and starts count.
// R04: Zero count halts, sets timeout status.
// R05: Host may set or clear status; expiry or force wins.
// R06: Keyboard, mouse, joystick reloads enabled apart.
// R07: Enabled event reloads count, clears status.
// R08: Mapped irq follows timeout status.
// R09: Force bit 2 zeroes count, sets status, self-clears.
// R10: Pin polarity, buffer type; default low open-drain.
// R11: Group SMI is OR of status AND enable.
// R12: Enable2 bit 7 to pin, bit 6 to IRQ2.
// R13: GPIO status on chosen edge or both.
// R14: GPIO status clears on one, not zero.
// R15: Keyboard-data SMI is status AND enable.
// R16: Edge select 0x21: falling or both; mouse polarity.
// R17: Keyboard-data both-edge SMI holds until cleared.
// R18: Mouse-data both-edge mode pulses per edge.
// R19: Mouse-data status clears by one; SMI follows line.
// R20: Device bits mirror; infrared clears on status2 read.
// R21: Sleep-enable write triggers event; type inert.
// R22: Sleep event is status7 bit 5, enable7 bit 5.
// R23: Unit ticks from prescaler restarted on reload.
`timescale 1ns/1ps
module wsa_top #(
	parameter int SECOND_CYCLES = wsa_pkg::WDT_SECOND_CYCLES
) (
	input wire logic clk_in, // Device clock, 40 MHz
	input wire logic rst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic [wsa_pkg::ADDR_W-1:0] reg_addr_in, // Runtime offset
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	input wire logic [wsa_pkg::DATA_W-1:0] reg_wdata_in, // Write data
	output logic [wsa_pkg::DATA_W-1:0] reg_rdata_out, // Read data
	input wire logic kbd_irq_in, // Keyboard irq
	input wire logic mouse_irq_in, // Mouse irq
	input wire logic joystick_access_in, // Joystick access
	input wire logic [wsa_pkg::DEV1_W-1:0] dev1_irq_in, // Bank 1 irqs
	input wire logic [wsa_pkg::DEV2_W-1:0] dev2_irq_in, // Bank 2 irqs
	input wire logic ir_irq_in, // Infrared irq
	input wire logic mouse_data_source_in, // Mouse data
	input wire logic keyboard_data_source_in, // Keyboard data
	input wire logic [wsa_pkg::GPIO_W-1:0] gpio_in, // Pin levels
	input wire logic [wsa_pkg::GPIO_W-1:0] gpio_pol_in, // Polarity
	input wire logic [wsa_pkg::GPIO_W-1:0] gpio_either_in, // Either edge
	output logic wdt_irq_out, // Watchdog irq
	output logic [wsa_pkg::CHAN_W-1:0] wdt_irq_chan_out, // Channel
	output logic group_smi_signal_out, // Group SMI
	output logic smi_output_pin_out, // Pin level
	output logic smi_output_pin_oe_out, // Pin drive
	output logic serirq_smi_out // IRQ2 slot
);
	import wsa_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] esel_q, cfg_q, units_q, reload_q, pinctl_q;
	logic [7:0] slp_lo_q, slp_hi_q, sts7_q, en7_q;
	logic [7:0] en1_q, en2_q;
	logic [GPIO_W-1:0] gsts_q, gen_q;
	logic [7:0] count_q;
	logic wdt_sts_q, p12_sts_q, p16_sts_q, ir_sts_q;
	logic [PULSE_W-1:0] p12_pulse_q;
	logic [7:0] rdata_d, sts1, sts2;
	logic wr, rd;

	assign wr = reg_wr_in && ce_in;
	assign rd = reg_rd_in && ce_in;

	function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
		hit = stb && (a == off);
	endfunction

	// Control registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			esel_q <= RST_REG;
			cfg_q <= RST_REG;
			units_q <= RST_REG;
			pinctl_q <= RST_REG;
			slp_lo_q <= RST_REG;
			slp_hi_q <= RST_REG;
			en1_q <= RST_REG;
			en2_q <= RST_REG;
			en7_q <= RST_REG;
			gen_q <= '0;
		end else if (ce_in) begin
			if (hit(wr, reg_addr_in, OFF_EDGE_SELECT)) esel_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_WDT_CONFIG)) cfg_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_WDT_UNITS)) units_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_PIN_CTRL)) pinctl_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SLEEP_LOW)) slp_lo_q <= reg_wdata_in;
			// R21: sleep type kept, no effect
			if (hit(wr, reg_addr_in, OFF_SLEEP_HIGH)) slp_hi_q <= reg_wdata_in & SLEEP_HIGH_MASK;
			if (hit(wr, reg_addr_in, OFF_SMI_EN1)) en1_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SMI_EN2)) en2_q <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SMI_ENABLE_SEVEN)) en7_q <= reg_wdata_in & STS7_MASK;
			if (hit(wr, reg_addr_in, OFF_SMI_EN3)) gen_q[7:0] <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SMI_EN4)) gen_q[15:8] <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SMI_EN5)) gen_q[23:16] <= reg_wdata_in;
			if (hit(wr, reg_addr_in, OFF_SMI_ENABLE_SEVEN)) gen_q[27:24] <= reg_wdata_in[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	logic wdt_load, wdt_evt, wdt_force, wdt_tick, wdt_expire, wdt_ctl_wr;
	logic [7:0] wdt_cnt_next;

	// R03: nonzero write loads counter
	assign wdt_load = hit(wr, reg_addr_in, OFF_WDT_RELOAD) && (reg_wdata_in != 8'h00);
	// R06: individually enabled reload events
	assign wdt_evt = ce_in && (reload_q != 8'h00) &&
		((kbd_irq_in && cfg_q[BIT_CFG_KBD]) || (mouse_irq_in && cfg_q[BIT_CFG_MOUSE]) ||
		(joystick_access_in && cfg_q[BIT_CFG_JOY]));
	assign wdt_ctl_wr = hit(wr, reg_addr_in, OFF_WDT_CONTROL);
	// R09: force request
	assign wdt_force = wdt_ctl_wr && reg_wdata_in[BIT_WDT_FORCE];
	// R04: expiry when last unit elapses
	assign wdt_expire = wdt_tick && (count_q == 8'h01) && !wdt_load && !wdt_evt && !wdt_force;
	assign wdt_cnt_next = count_q - 8'h01;

	// R23: unit ticks, restarted on reload
	wsa_prescaler #(
		.SEC_CYCLES(SECOND_CYCLES),
		.MIN_SECONDS(WDT_MINUTE_SECONDS)
	) u_prescaler (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.run_in(count_q != 8'h00),
		.restart_in(hit(wr, reg_addr_in, OFF_WDT_RELOAD) || wdt_evt || wdt_force),
		.minutes_in(units_q[BIT_UNITS_MIN]),
		.tick_out(wdt_tick)
	);

	// Reload value
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// R02: disabled after reset
			reload_q <= RST_WDT_RELOAD;
		end else if (hit(wr, reg_addr_in, OFF_WDT_RELOAD)) begin
			reload_q <= reg_wdata_in;
		end
	end

	// Countdown register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q <= 8'h00;
		end else if (ce_in) begin
			if (wdt_force) begin
				// R09: count forced to zero
				count_q <= 8'h00;
			end else if (hit(wr, reg_addr_in, OFF_WDT_RELOAD)) begin
				// R02: zero write stops counting
				count_q <= reg_wdata_in;
			end else if (wdt_evt) begin
				// R07: reload stored value
				count_q <= reload_q;
			end else if (wdt_tick && count_q != 8'h00) begin
				// R01: one unit per tick
				count_q <= wdt_cnt_next;
			end
		end
	end

	// Timeout status
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdt_sts_q <= 1'b0;
		end else if (ce_in) begin
			if (wdt_force || wdt_expire) begin
				// R04: set on expiry or force
				wdt_sts_q <= 1'b1;
			end else if (wdt_ctl_wr) begin
				// R05: direct host set or clear
				wdt_sts_q <= reg_wdata_in[BIT_WDT_STATUS];
			end else if (wdt_evt) begin
				// R07: reload clears status
				wdt_sts_q <= 1'b0;
			end
		end
	end

	// Watchdog irq
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdt_irq_out <= 1'b0;
			wdt_irq_chan_out <= '0;
		end else if (ce_in) begin
			wdt_irq_chan_out <= cfg_q[LSB_CFG_CHAN +: CHAN_W];
			// R08: level follows status
			wdt_irq_out <= (cfg_q[LSB_CFG_CHAN +: CHAN_W] != '0) && wdt_sts_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge-triggered sources
	logic [GPIO_W-1:0] g_evt;
	logic [1:0] kb_evt;

	// R13: GPIO edge or either-edge
	wsa_edge_det #(
		.W(GPIO_W)
	) u_gpio_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.sig_in(gpio_in),
		.pol_in(gpio_pol_in),
		.both_in(gpio_either_in),
		.evt_out(g_evt)
	);

	// R16: falling or both edges; mouse polarity select
	wsa_edge_det #(
		.W(2)
	) u_kbms_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.sig_in({keyboard_data_source_in, mouse_data_source_in}),
		.pol_in({1'b1, ~esel_q[BIT_ES_P12_POL]}),
		.both_in({esel_q[BIT_ES_P16_BOTH], esel_q[BIT_ES_P12_BOTH]}),
		.evt_out(kb_evt)
	);

	// GPIO status, edge wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gsts_q <= '0;
		end else if (ce_in) begin
			// R14: write-one-to-clear
			gsts_q <= (gsts_q & ~{
				hit(wr, reg_addr_in, OFF_SMI_STATUS_SEVEN) ? reg_wdata_in[3:0] : 4'h0,
				hit(wr, reg_addr_in, OFF_SMI_STS5) ? reg_wdata_in : 8'h00,
				hit(wr, reg_addr_in, OFF_SMI_STS4) ? reg_wdata_in : 8'h00,
				hit(wr, reg_addr_in, OFF_SMI_STS3) ? reg_wdata_in : 8'h00}) | g_evt;
		end
	end

	// Sleep event status
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sts7_q <= RST_REG;
		end else if (ce_in) begin
			if (hit(wr, reg_addr_in, OFF_SMI_STATUS_SEVEN) && reg_wdata_in[BIT_STS7_SLEEP]) begin
				sts7_q[BIT_STS7_SLEEP] <= 1'b0;
			end
			// R21: sleep enable write triggers
			// R22: status7 bit 5
			if (hit(wr, reg_addr_in, OFF_SLEEP_HIGH) && reg_wdata_in[BIT_SLEEP_EN]) begin
				sts7_q[BIT_STS7_SLEEP] <= 1'b1;
			end
		end
	end

	// Data-line and infrared status
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			p12_sts_q <= 1'b0;
			p16_sts_q <= 1'b0;
			ir_sts_q <= 1'b0;
		end else if (ce_in) begin
			// R15: keyboard-data clear by one
			// R19: mouse-data clear by one
			if (hit(wr, reg_addr_in, OFF_SMI_STATUS_TWO)) begin
				if (reg_wdata_in[0]) p12_sts_q <= 1'b0;
				if (reg_wdata_in[1]) p16_sts_q <= 1'b0;
			end
			if (kb_evt[0]) p12_sts_q <= 1'b1;
			// R17: held until cleared
			if (kb_evt[1]) p16_sts_q <= 1'b1;
			// R20: infrared clears on read
			if (hit(rd, reg_addr_in, OFF_SMI_STATUS_TWO)) ir_sts_q <= 1'b0;
			if (ir_irq_in) ir_sts_q <= 1'b1;
		end
	end

	// R18: short pulse per mouse-data edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			p12_pulse_q <= '0;
		end else if (ce_in) begin
			if (kb_evt[0] && esel_q[BIT_ES_P12_BOTH]) begin
				p12_pulse_q <= PULSE_W'(P12_PULSE_CYCLES);
			end else if (p12_pulse_q != '0) begin
				p12_pulse_q <= p12_pulse_q - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SMI aggregation
	logic p12_term, grp;

	// R20: device bits mirror sources
	assign sts1 = {dev1_irq_in, wdt_sts_q};
	assign sts2 = {2'b00, dev2_irq_in, ir_sts_q, p16_sts_q, p12_sts_q};
	// R19: single-edge SMI follows source line
	assign p12_term = en2_q[0] && (esel_q[BIT_ES_P12_BOTH] ? (p12_pulse_q != '0) :
		(mouse_data_source_in == esel_q[BIT_ES_P12_POL]));
	// R11: OR of status AND enable
	// R15: keyboard-data term latched
	assign grp = (|(sts1 & en1_q)) || p12_term || (|(sts2[5:1] & en2_q[5:1])) ||
		(|(gsts_q & gen_q)) || (|(sts7_q & en7_q));

	// Output drivers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			group_smi_signal_out <= 1'b0;
			serirq_smi_out <= 1'b0;
			smi_output_pin_out <= 1'b0;
			smi_output_pin_oe_out <= 1'b0;
		end else if (ce_in) begin
			group_smi_signal_out <= grp;
			// R12: IRQ2 routing
			serirq_smi_out <= grp && en2_q[BIT_EN2_SERIRQ];
			// R12: pin routing
			// R10: polarity and buffer type
			if (pinctl_q[BIT_PIN_PUSHPULL]) begin
				smi_output_pin_oe_out <= 1'b1;
				smi_output_pin_out <= (grp && en2_q[BIT_EN2_PIN]) == pinctl_q[BIT_PIN_POL];
			end else begin
				smi_output_pin_out <= 1'b0;
				smi_output_pin_oe_out <= (grp && en2_q[BIT_EN2_PIN]) != pinctl_q[BIT_PIN_POL];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data path
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			OFF_EDGE_SELECT: rdata_d = esel_q;
			OFF_WDT_CONFIG: rdata_d = cfg_q;
			OFF_WDT_UNITS: rdata_d = units_q;
			OFF_WDT_RELOAD: rdata_d = reload_q;
			OFF_WDT_CONTROL: rdata_d = {7'h00, wdt_sts_q};
			OFF_PIN_CTRL: rdata_d = pinctl_q;
			OFF_SLEEP_LOW: rdata_d = slp_lo_q;
			OFF_SLEEP_HIGH: rdata_d = slp_hi_q;
			OFF_SMI_STS1: rdata_d = sts1;
			OFF_SMI_STATUS_TWO: rdata_d = sts2;
			OFF_SMI_STS3: rdata_d = gsts_q[7:0];
			OFF_SMI_STS4: rdata_d = gsts_q[15:8];
			OFF_SMI_STS5: rdata_d = gsts_q[23:16];
			OFF_SMI_STATUS_SEVEN: rdata_d = sts7_q | {4'h0, gsts_q[27:24]};
			OFF_SMI_EN1: rdata_d = en1_q;
			OFF_SMI_EN2: rdata_d = en2_q;
			OFF_SMI_EN3: rdata_d = gen_q[7:0];
			OFF_SMI_EN4: rdata_d = gen_q[15:8];
			OFF_SMI_EN5: rdata_d = gen_q[23:16];
			OFF_SMI_ENABLE_SEVEN: rdata_d = en7_q | {4'h0, gen_q[27:24]};
			default: rdata_d = 8'h00;
		endcase
	end

	// Registered read data
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (rd) begin
			reg_rdata_out <= rdata_d;
		end
	end
endmodule

// ==== wsa_top_tb.sv ====
/*
 Self-checking bench for the watchdog and SMI aggregator.
 Assumes host model drives registers; second = 8 cycles.
*/
`timescale 1ns/1ps
module wsa_top_tb;
	import wsa_pkg::*;
	localparam int SEC = 8;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [2:0] evt = 3'h0;
	logic ir = 1'b0;
	logic kdat = 1'b1;
	logic [GPIO_W-1:0] gpio = '0;
	logic [GPIO_W-1:0] gpio_pol = '0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, irq, group, pin, oe, serirq, smi_wire;
	logic [3:0] chan;
	int err_total = 0;
	int check_count = 0;
	int n, e;
	wsa_top #(.SECOND_CYCLES(SEC)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .kbd_irq_in(evt[0]), .mouse_irq_in(evt[1]),
		.joystick_access_in(evt[2]), .dev1_irq_in(7'h00), .dev2_irq_in(3'h0), .ir_irq_in(ir),
		.mouse_data_source_in(1'b1), .keyboard_data_source_in(kdat), .gpio_in(gpio),
		.gpio_pol_in(gpio_pol), .gpio_either_in(28'h0), .wdt_irq_out(irq),
		.wdt_irq_chan_out(chan), .group_smi_signal_out(group), .smi_output_pin_out(pin),
		.smi_output_pin_oe_out(oe), .serirq_smi_out(serirq));
	wsa_host_model host_u (.clk_in(clk_in), .rdata_in(rdata), .pin_in(pin), .oe_in(oe),
		.addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .smi_wire_out(smi_wire));
	////////////////////////////////////////////////////////////////////////////
	// Clock, 25 ns period
	initial forever #12.5 clk_in = ~clk_in;
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded irq wait
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > lim) begin
				err_total++;
				end_sim();
			end
		end
	endtask
	task automatic settle;
		repeat (3) @(negedge clk_in);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		host_u.rd(OFF_WDT_RELOAD, d);
		check("reload rst", d, 8'h00);
		host_u.rd(8'h30, d);
		check("unmapped", d, 8'h00);
		check("pin rst", {6'h0, oe, smi_wire}, 8'h01);
	endtask
	task automatic t_timeout;
		host_u.wr(OFF_WDT_CONFIG, 8'h10);
		for (int u = 0; u < 2; u++) begin
			host_u.wr(OFF_WDT_CONTROL, 8'h00);
			host_u.wr(OFF_WDT_UNITS, u ? 8'h80 : 8'h00);
			host_u.wr(OFF_WDT_RELOAD, 8'h02);
			wait_irq(2000);
			e = 2 * SEC * (u ? 60 : 1);
			check("expiry", {7'h0, n >= e && n <= e + 3}, 8'h01);
			host_u.rd(OFF_WDT_CONTROL, d);
			check("wdt sts", d & 8'h05, 8'h01);
		end
		check("chan", {4'h0, chan}, 8'h01);
		host_u.wr(OFF_WDT_UNITS, 8'h00);
		host_u.wr(OFF_WDT_CONTROL, 8'h00);
		host_u.wr(OFF_WDT_RELOAD, 8'h03);
		host_u.wr(OFF_WDT_RELOAD, 8'h00);
		repeat (40) @(negedge clk_in);
		check("disabled", {7'h0, irq}, 8'h00);
	endtask
	task automatic t_reload;
		for (int i = 0; i < 6; i++) begin
			host_u.wr(OFF_WDT_CONFIG, 8'h10 | (i < 3 ? 8'h01 << i : 8'h00));
			host_u.wr(OFF_WDT_RELOAD, 8'h01);
			wait_irq(60);
			@(posedge clk_in);
			evt <= 3'h1 << (i % 3);
			@(posedge clk_in);
			evt <= 3'h0;
			host_u.rd(OFF_WDT_CONTROL, d);
			check("event", d & 8'h01, i < 3 ? 8'h00 : 8'h01);
		end
	endtask
	task automatic t_status;
		host_u.wr(OFF_WDT_RELOAD, 8'hc8);
		host_u.wr(OFF_WDT_CONTROL, 8'h01);
		host_u.rd(OFF_WDT_CONTROL, d);
		check("sts set", d & 8'h05, 8'h01);
		host_u.wr(OFF_WDT_CONTROL, 8'h00);
		host_u.rd(OFF_WDT_CONTROL, d);
		check("sts clr", d & 8'h05, 8'h00);
		host_u.wr(OFF_WDT_CONTROL, 8'h04);
		host_u.rd(OFF_WDT_CONTROL, d);
		check("force", d & 8'h05, 8'h01);
	endtask
	task automatic t_route;
		host_u.wr(OFF_SMI_EN1, 8'h01);
		host_u.wr(OFF_SMI_EN2, 8'h80);
		settle();
		check("od on", {4'h0, group, oe, smi_wire, serirq}, 8'h0c);
		host_u.wr(OFF_SMI_EN2, 8'h40);
		settle();
		check("serirq", {5'h0, oe, smi_wire, serirq}, 8'h03);
		host_u.wr(OFF_PIN_CTRL, 8'h81);
		host_u.wr(OFF_SMI_EN2, 8'h80);
		settle();
		check("pp on", {6'h0, oe, pin}, 8'h03);
		host_u.wr(OFF_SMI_EN1, 8'h00);
		settle();
		check("pp off", {5'h0, group, oe, pin}, 8'h02);
		host_u.wr(OFF_PIN_CTRL, 8'h00);
	endtask
	task automatic t_sleep;
		host_u.wr(OFF_SMI_ENABLE_SEVEN, 8'h20);
		host_u.wr(OFF_SLEEP_HIGH, 8'h3c);
		host_u.rd(OFF_SLEEP_HIGH, d);
		check("sleep rd", d, 8'h1c);
		host_u.rd(OFF_SMI_STATUS_SEVEN, d);
		check("sts7", {group, d[6:0] & 7'h20}, 8'ha0);
		host_u.wr(OFF_SMI_STATUS_SEVEN, 8'h20);
		settle();
		check("sts7 clr", {7'h0, group}, 8'h00);
	endtask
	// GPIO step, zero write must not clear
	task automatic gp(input logic v, input logic p, input logic [7:0] e);
		@(posedge clk_in);
		gpio[0] <= v;
		gpio_pol[0] <= p;
		settle();
		host_u.wr(OFF_SMI_STS3, 8'h00);
		host_u.rd(OFF_SMI_STS3, d);
		check("gpio sts", d & 8'h01, e);
		host_u.wr(OFF_SMI_STS3, 8'h01);
	endtask
	task automatic t_edges;
		gp(1'b1, 1'b0, 8'h01);
		gp(1'b0, 1'b0, 8'h00);
		gp(1'b1, 1'b1, 8'h00);
		gp(1'b0, 1'b1, 8'h01);
		gp(1'b1, 1'b0, 8'h01);
		host_u.wr(OFF_SMI_EN3, 8'h01);
		gp(1'b0, 1'b1, 8'h01);
		host_u.wr(OFF_SMI_STS3, 8'h00);
		host_u.rd(OFF_SMI_STS3, d);
		check("gpio w0", d & 8'h01, 8'h00);
		@(posedge clk_in);
		kdat <= 1'b0;
		ir <= 1'b1;
		@(posedge clk_in);
		ir <= 1'b0;
		settle();
		host_u.rd(OFF_SMI_STATUS_TWO, d);
		check("kbd ir", d & 8'h06, 8'h06);
		host_u.wr(OFF_SMI_STATUS_TWO, 8'h02);
		host_u.rd(OFF_SMI_STATUS_TWO, d);
		check("kbd clr", d & 8'h06, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Reset, then scenarios
	initial begin
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_timeout();
		t_reload();
		t_status();
		t_route();
		t_sleep();
		t_edges();
		end_sim();
	end
endmodule
